// >>> rtl/pvac_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PVAC_DEFS_SVH
`define PVAC_DEFS_SVH
// register byte addresses on the bus
`define PVAC_OFF_KHOLD      12'h000
`define PVAC_OFF_KRUN       12'h004
`define PVAC_OFF_KACC       12'h008
`define PVAC_OFF_KDEC       12'h00C
`define PVAC_OFF_INTSPD     12'h010
`define PVAC_OFF_STSLP      12'h014
`define PVAC_OFF_FNACC      12'h018
`define PVAC_OFF_FNDEC      12'h01C
`define PVAC_OFF_KTHERM     12'h020
`define PVAC_OFF_ADCOUT     12'h024
`define PVAC_OFF_CONFIG     12'h028
`define PVAC_OFF_MINSPD     12'h02C
`define PVAC_OFF_IRQSTAT    12'h030
`define PVAC_OFF_IRQMASK    12'h034
`define PVAC_OFF_AMP        12'h038
// field positions
`define PVAC_CFG_SUPPLY_CORRECTION_ENABLE  5
`define PVAC_CFG_MUL_LSB    10
`define PVAC_CFG_DIV_LSB    13
`define PVAC_MINSPD_LSPD    12
`define PVAC_IRQ_STALL_A    0
`define PVAC_IRQ_STALL_B    1
`define PVAC_IRQ_ADC        2
// reset values
`define PVAC_RST_KVAL       8'h29
`define PVAC_RST_INTSPD     14'h0408
`define PVAC_RST_STSLP      8'h19
`define PVAC_RST_FNSLP      8'h29
`define PVAC_RST_KTHERM     4'h0
`define PVAC_RST_CONFIG     16'h2E88
`define PVAC_RST_MINSPD     13'h0000
// converter: 5 bits, half scale means nominal supply
`define PVAC_ADC_BITS       5
`define PVAC_ADC_HALF       5'h10
`define PVAC_PWM_BASE       10'h200
// clock cycles per oscillator tick; keeps m/(8n) at or below one tick a cycle
`define PVAC_OSC_PRESCALE   8
`endif

// >>> rtl/pvac_pkg.sv
// shared types for the phase voltage amplitude block
package pvac_pkg;
    typedef enum logic [3:0] {
        PVAC_PH_HOLD = 4'b0001,
        PVAC_PH_ACC  = 4'b0010,
        PVAC_PH_DEC  = 4'b0100,
        PVAC_PH_RUN  = 4'b1000
    } pvac_phase_e;
    typedef enum logic [2:0] {
        PVAC_ADC_IDLE = 3'b001,
        PVAC_ADC_RAMP = 3'b010,
        PVAC_ADC_DONE = 3'b100
    } pvac_adc_e;
endpackage

// >>> rtl/pvac_adc.sv
// ramp-compare converter sequencer for the supply sense input
`timescale 1ns/10ps
`include "pvac_defs.svh"
module pvac_adc
    import pvac_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic       cmp_in,
    output logic [4:0]      ramp_out,
    output logic [4:0]      result_out,
    output logic            done_out
);
    pvac_adc_e   st_q, st_d;
    logic [4:0]  ramp_q, ramp_d;
    logic [4:0]  res_q, res_d;
    logic        done_q, done_d;
    logic [2:0]  sync_q;
    logic        cmp_hi_q;

    // three-stage sync; a change counts once stages two and three agree
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync_q   <= 3'h0;
            cmp_hi_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], cmp_in};
            if (sync_q[1] == sync_q[2]) begin
                cmp_hi_q <= sync_q[2];
            end
        end
    end

    // ramp rises one code per cycle until the comparator trips
    always_comb begin
        st_d   = st_q;
        ramp_d = ramp_q;
        res_d  = res_q;
        done_d = 1'b0;
        unique case (st_q)
            PVAC_ADC_IDLE: begin
                if (start_in) begin
                    st_d   = PVAC_ADC_RAMP;
                    ramp_d = 5'h00;
                end
            end
            PVAC_ADC_RAMP: begin
                // sync delay is accepted: it biases by a fixed few codes
                if (cmp_hi_q || ramp_q == 5'h1F) begin
                    res_d = ramp_q;
                    st_d  = PVAC_ADC_DONE;
                end else begin
                    ramp_d = ramp_q + 5'h01;
                end
            end
            PVAC_ADC_DONE: begin
                done_d = 1'b1;
                st_d   = PVAC_ADC_IDLE;
            end
            default: st_d = PVAC_ADC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q   <= PVAC_ADC_IDLE;
            ramp_q <= 5'h00;
            res_q  <= `PVAC_ADC_HALF;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            ramp_q <= ramp_d;
            res_q  <= res_d;
            done_q <= done_d;
        end
    end

    assign ramp_out   = ramp_q;
    assign result_out = res_q;
    assign done_out   = done_q;
endmodule

// >>> rtl/pvac_pwm.sv
// one pwm modulator for a bridge; duty compared against a 9-bit carrier
`timescale 1ns/10ps
`include "pvac_defs.svh"
module pvac_pwm (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       tick_in,
    input  wire logic [8:0] duty_in,
    output logic            pwm_out,
    output logic            wrap_out
);
    logic [8:0] cnt_q, cnt_d;
    logic       pwm_q, pwm_d;
    logic       wrap_q, wrap_d;

    // carrier advances on each tick, 512 ticks per pwm period
    always_comb begin
        cnt_d  = cnt_q;
        pwm_d  = pwm_q;
        wrap_d = 1'b0;
        if (tick_in) begin
            cnt_d  = cnt_q + 9'h001;
            pwm_d  = (cnt_q < duty_in);
            wrap_d = (cnt_q == 9'h1FF);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cnt_q  <= 9'h000;
            pwm_q  <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pwm_q  <= pwm_d;
            wrap_q <= wrap_d;
        end
    end

    assign pwm_out  = pwm_q;
    assign wrap_out = wrap_q;
endmodule

// >>> rtl/pvac_top.sv
// phase voltage amplitude control: kval chain, pwm pair, stall flags
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "pvac_defs.svh"
module pvac_top
    import pvac_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // motion state from the speed profiler
    input  wire logic [3:0]  motion_phase_in,
    input  wire logic [19:0] speed_in,
    input  wire logic [7:0]  microstep_in,
    input  wire logic        status_read_command_in,
    // current comparator stall pulses, per bridge
    input  wire logic        stall_a_in,
    input  wire logic        stall_b_in,
    input  wire logic        adc_cmp_in,
    output logic       [4:0] adc_ramp_out,
    output logic             pwm_a_out,
    output logic             pwm_b_out,
    output logic             stall_flag_a_n_out,
    output logic             stall_flag_b_n_out,
    output logic      [12:0] profile_min_speed_out,
    output logic             low_speed_active_out,
    output logic             irq_out
);
    // ******************************************************
    // registers
    // ******************************************************
    logic [7:0]  khold_q, krun_q, kacc_q, kdec_q;
    logic [13:0] intspd_q;
    logic [7:0]  stslp_q, fnacc_q, fndec_q;
    logic [3:0]  ktherm_q;
    logic [15:0] config_q;
    logic [12:0] minspd_q;
    logic        lspd_q;
    logic [2:0]  irqstat_q, irqstat_d;
    logic [2:0]  irqmask_q;
    logic [4:0]  adcout_q;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pslverr_q, pslverr_d;
    logic        irq_q;
    logic [7:0]  amp_q;
    logic        wr_en, rd_hit;
    logic [2:0]  events;

    // write strobe at the access edge; slave answers with no wait state
    assign wr_en = psel && penable && pwrite && pready_q;

    // address decode, unmapped reads give zero with an error answer
    always_comb begin
        prdata_d  = 32'h0000_0000;
        rd_hit    = 1'b1;
        unique case (paddr)
            `PVAC_OFF_KHOLD:   prdata_d = {24'h0, khold_q};
            `PVAC_OFF_KRUN:    prdata_d = {24'h0, krun_q};
            `PVAC_OFF_KACC:    prdata_d = {24'h0, kacc_q};
            `PVAC_OFF_KDEC:    prdata_d = {24'h0, kdec_q};
            `PVAC_OFF_INTSPD:  prdata_d = {18'h0, intspd_q};
            `PVAC_OFF_STSLP:   prdata_d = {24'h0, stslp_q};
            `PVAC_OFF_FNACC:   prdata_d = {24'h0, fnacc_q};
            `PVAC_OFF_FNDEC:   prdata_d = {24'h0, fndec_q};
            `PVAC_OFF_KTHERM:  prdata_d = {28'h0, ktherm_q};
            `PVAC_OFF_ADCOUT:  prdata_d = {27'h0, adcout_q};
            `PVAC_OFF_CONFIG:  prdata_d = {16'h0, config_q};
            // the fix enable is bit 12 of the stored word itself
            `PVAC_OFF_MINSPD:  prdata_d = {19'h0, minspd_q};
            `PVAC_OFF_IRQSTAT: prdata_d = {29'h0, irqstat_q};
            `PVAC_OFF_IRQMASK: prdata_d = {29'h0, irqmask_q};
            `PVAC_OFF_AMP:     prdata_d = {24'h0, amp_q};
            default:           rd_hit   = 1'b0;
        endcase
        pslverr_d = psel && !penable && !rd_hit;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            khold_q   <= `PVAC_RST_KVAL;
            krun_q    <= `PVAC_RST_KVAL;
            kacc_q    <= `PVAC_RST_KVAL;
            kdec_q    <= `PVAC_RST_KVAL;
            intspd_q  <= `PVAC_RST_INTSPD;
            stslp_q   <= `PVAC_RST_STSLP;
            fnacc_q   <= `PVAC_RST_FNSLP;
            fndec_q   <= `PVAC_RST_FNSLP;
            ktherm_q  <= `PVAC_RST_KTHERM;
            config_q  <= `PVAC_RST_CONFIG;
            minspd_q  <= `PVAC_RST_MINSPD;
            lspd_q    <= 1'b0;
            irqmask_q <= 3'h0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            // pready is raised in setup so the access phase is one cycle
            pready_q  <= psel && !penable;
            pslverr_q <= pslverr_d;
            if (psel && !penable) begin
                prdata_q <= prdata_d;
            end
            if (wr_en) begin
                unique case (paddr)
                    `PVAC_OFF_KHOLD:   khold_q  <= pwdata[7:0];
                    `PVAC_OFF_KRUN:    krun_q   <= pwdata[7:0];
                    `PVAC_OFF_KACC:    kacc_q   <= pwdata[7:0];
                    `PVAC_OFF_KDEC:    kdec_q   <= pwdata[7:0];
                    `PVAC_OFF_INTSPD:  intspd_q <= pwdata[13:0];
                    `PVAC_OFF_STSLP:   stslp_q  <= pwdata[7:0];
                    `PVAC_OFF_FNACC:   fnacc_q  <= pwdata[7:0];
                    `PVAC_OFF_FNDEC:   fndec_q  <= pwdata[7:0];
                    // thermal factor is set by host firmware only
                    `PVAC_OFF_KTHERM:  ktherm_q <= pwdata[3:0];
                    `PVAC_OFF_CONFIG:  config_q <= pwdata[15:0];
                    `PVAC_OFF_MINSPD: begin
                        minspd_q <= pwdata[12:0];
                        lspd_q   <= pwdata[`PVAC_MINSPD_LSPD];
                    end
                    `PVAC_OFF_IRQMASK: irqmask_q <= pwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ******************************************************
    // pwm rate divider
    // ******************************************************
    logic [2:0]  div_n;
    logic [2:0]  mul_m;
    logic [6:0]  acc_q, acc_d;
    logic [6:0]  lim;
    logic        tick_q, tick_d;
    logic        wrap_a, wrap_b;

    // n = field+1, m = field+1; accumulator adds m, wraps at 8n, since
    // the oscillator is the clock over 8 so m > n never needs two ticks
    assign div_n = config_q[`PVAC_CFG_DIV_LSB +: 3];
    assign mul_m = config_q[`PVAC_CFG_MUL_LSB +: 3];
    assign lim   = 7'(({4'h0, div_n} + 7'h01) * `PVAC_OSC_PRESCALE);

    always_comb begin
        acc_d  = acc_q + {4'h0, mul_m} + 7'h01;
        tick_d = 1'b0;
        if (acc_d >= lim) begin
            acc_d  = acc_d - lim;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            acc_q  <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    // ******************************************************
    // converter, sampled once per pwm period
    // ******************************************************
    logic [4:0] adc_res;
    logic       adc_done;

    pvac_adc u_adc (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (wrap_a),
        .cmp_in      (adc_cmp_in),
        .ramp_out    (adc_ramp_out),
        .result_out  (adc_res),
        .done_out    (adc_done)
    );

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            adcout_q <= `PVAC_ADC_HALF;
        end else if (adc_done) begin
            adcout_q <= adc_res;
        end
    end

    // ******************************************************
    // amplitude chain
    // ******************************************************
    logic [7:0]  kstart;
    logic [7:0]  fnslp;
    logic [19:0] knee;
    logic [27:0] bemf_full;
    logic [7:0]  bemf;
    logic [8:0]  ksum;
    logic [13:0] vs_prod;
    logic [8:0]  ks_vs;
    logic [13:0] th_prod;
    logic [8:0]  ks_th;
    logic [16:0] ms_prod;
    logic [7:0]  amp_d;
    logic        running;
    logic [4:0]  adc_div;

    assign running = (motion_phase_in != PVAC_PH_HOLD);

    // start coefficient per motion phase
    always_comb begin
        unique case (motion_phase_in)
            PVAC_PH_ACC: kstart = kacc_q;
            PVAC_PH_DEC: kstart = kdec_q;
            PVAC_PH_RUN: kstart = krun_q;
            default:     kstart = khold_q;
        endcase
    end

    // two-segment back-emf curve; speed scaled down 2^12
    always_comb begin
        fnslp = (motion_phase_in == PVAC_PH_DEC) ? fndec_q : fnacc_q;
        knee  = {6'h0, intspd_q};
        if (speed_in <= {6'h0, intspd_q}) begin
            bemf_full = speed_in * stslp_q;
        end else begin
            bemf_full = knee * stslp_q + (speed_in - knee) * fnslp;
        end
        if (!running) begin
            bemf = 8'h00;
        end else if (bemf_full[27:20] != 8'h00) begin
            bemf = 8'hFF;
        end else begin
            bemf = bemf_full[19:12];
        end
    end

    // supply and thermal factors; saturating to full scale
    always_comb begin
        ksum    = {1'b0, kstart} + {1'b0, bemf};
        adc_div = (adcout_q == 5'h00) ? 5'h01 : adcout_q;
        if (config_q[`PVAC_CFG_SUPPLY_CORRECTION_ENABLE]) begin
            // factor = half / reading, unity at half scale
            vs_prod = 14'(({5'h0, ksum} * 14'(`PVAC_ADC_HALF))
                      / {9'h0, adc_div});
        end else begin
            vs_prod = {5'h0, ksum};
        end
        ks_vs   = (vs_prod > 14'h01FF) ? 9'h1FF : vs_prod[8:0];
        // factor = 1 + k/16, so zero means unity
        th_prod = {5'h0, ks_vs} + 14'(({5'h0, ks_vs}
                  * {10'h0, ktherm_q}) >> 4);
        ks_th   = (th_prod > 14'h00FF) ? 9'h0FF : th_prod[8:0];
        ms_prod = {8'h0, ks_th} * {9'h0, microstep_in};
        amp_d   = ms_prod[15:8];
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            amp_q <= 8'h00;
        end else begin
            amp_q <= amp_d;
        end
    end

    // ******************************************************
    // modulators, one per bridge
    // ******************************************************
    pvac_pwm u_pwm_a (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_in     (tick_q),
        .duty_in     ({amp_q, 1'b0}),
        .pwm_out     (pwm_a_out),
        .wrap_out    (wrap_a)
    );
    pvac_pwm u_pwm_b (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_in     (tick_q),
        .duty_in     ({amp_q, 1'b0}),
        .pwm_out     (pwm_b_out),
        .wrap_out    (wrap_b)
    );

    // ******************************************************
    // stall flags, low speed fix and interrupt
    // ******************************************************
    logic flag_a_q, flag_b_q;
    logic lsa_q;
    logic [12:0] pmin_q;

    always_comb begin
        events    = {adc_done, stall_b_in, stall_a_in};
        irqstat_d = irqstat_q;
        if (wr_en && paddr == `PVAC_OFF_IRQSTAT) begin
            irqstat_d = irqstat_q & ~pwdata[2:0];
        end
        // a set in the clearing cycle wins
        irqstat_d = irqstat_d | events;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            flag_a_q  <= 1'b1;
            flag_b_q  <= 1'b1;
            irqstat_q <= 3'h0;
            irq_q     <= 1'b0;
            lsa_q     <= 1'b0;
            pmin_q    <= 13'h0000;
        end else begin
            // stall beats a status read in the same cycle
            if (stall_a_in) begin
                flag_a_q <= 1'b0;
            end else if (status_read_command_in) begin
                flag_a_q <= 1'b1;
            end
            if (stall_b_in) begin
                flag_b_q <= 1'b0;
            end else if (status_read_command_in) begin
                flag_b_q <= 1'b1;
            end
            irqstat_q <= irqstat_d;
            irq_q     <= |(irqstat_d & irqmask_q);
            lsa_q     <= lspd_q && (speed_in <= {7'h0, minspd_q});
            pmin_q    <= lspd_q ? 13'h0000 : minspd_q;
        end
    end

    assign stall_flag_a_n_out    = flag_a_q;
    assign stall_flag_b_n_out    = flag_b_q;
    assign irq_out               = irq_q;
    assign low_speed_active_out  = lsa_q;
    assign profile_min_speed_out = pmin_q;

    // ******************************************************
    // checks
    // ******************************************************
    property p_stall_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        stall_a_in |=> !stall_flag_a_n_out;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("bridge a flag not low after stall");

    property p_min_zero;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        lspd_q |=> profile_min_speed_out == 13'h0000;
    endproperty
    a_min_zero: assert property (p_min_zero)
        else $error("profile minimum not forced to zero");

    property p_stall_b_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        stall_b_in |=> !stall_flag_b_n_out;
    endproperty
    a_stall_b_hold: assert property (p_stall_b_hold)
        else $error("bridge b flag not low after stall");

    property p_flag_release;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !stall_a_in && status_read_command_in |=> stall_flag_a_n_out;
    endproperty
    a_flag_release: assert property (p_flag_release)
        else $error("bridge a flag not released by status read");

    property p_hold_no_bemf;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !running |-> bemf == 8'h00;
    endproperty
    a_hold_no_bemf: assert property (p_hold_no_bemf)
        else $error("back-emf added while stopped");

    property p_lspd_active;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        lspd_q && (speed_in <= {7'h0, minspd_q}) |=> low_speed_active_out;
    endproperty
    a_lspd_active: assert property (p_lspd_active)
        else $error("low speed fix not active below minimum");
endmodule

// >>> tb/pvac_supply_model.sv
// supply sense divider and ramp comparator seen by the converter
`timescale 1ns/10ps
module pvac_supply_model (
    input  wire logic       core_clk_in,
    input  wire logic [4:0] ramp_in,
    input  wire logic [4:0] level_in,
    output logic            cmp_out
);
    // comparator trips once the ramp reaches the divided supply level;
    // registered so the synchroniser in the block sees a clean edge
    always_ff @(posedge core_clk_in) begin
        cmp_out <= (ramp_in >= level_in);
    end
endmodule

// >>> tb/phase_voltage_amplitude_control_bench.sv
// self-checking bench for the phase voltage amplitude block
`timescale 1ns/10ps
`include "pvac_defs.svh"
module phase_voltage_amplitude_control_bench;
    import pvac_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  phase;
    logic [19:0] speed;
    logic [7:0]  ustep;
    logic        srd, st_a, st_b, cmp, pwm_a, pwm_b, fl_a_n, fl_b_n;
    logic        lsa, irq, err, irq0;
    logic [4:0]  ramp, level;
    logic [12:0] pmin;
    int          fails, check_count, gap;
    int unsigned mdl [11];
    logic [11:0] ra [11] = '{`PVAC_OFF_KHOLD, `PVAC_OFF_KRUN,
        `PVAC_OFF_KACC, `PVAC_OFF_KDEC, `PVAC_OFF_INTSPD, `PVAC_OFF_STSLP,
        `PVAC_OFF_FNACC, `PVAC_OFF_FNDEC, `PVAC_OFF_KTHERM,
        `PVAC_OFF_CONFIG, `PVAC_OFF_MINSPD};
    int unsigned msk [11] = '{32'h0000_00ff, 32'h0000_00ff, 32'h0000_00ff,
        32'h0000_00ff, 32'h0000_3fff, 32'h0000_00ff, 32'h0000_00ff,
        32'h0000_00ff, 32'h0000_000f, 32'h0000_ffff, 32'h0000_1fff};

    pvac_top uut (.core_clk_in(clk), .rst_n_in(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motion_phase_in(phase), .speed_in(speed), .microstep_in(ustep),
        .status_read_command_in(srd), .stall_a_in(st_a), .stall_b_in(st_b),
        .adc_cmp_in(cmp), .adc_ramp_out(ramp), .pwm_a_out(pwm_a),
        .pwm_b_out(pwm_b), .stall_flag_a_n_out(fl_a_n),
        .stall_flag_b_n_out(fl_b_n), .profile_min_speed_out(pmin),
        .low_speed_active_out(lsa), .irq_out(irq));
    pvac_supply_model sup (.core_clk_in(clk), .ramp_in(ramp),
        .level_in(level), .cmp_out(cmp));

    // 25 MHz clock
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // every wait below is bounded by this watchdog, so a hang still ends
    initial begin
        #(40 * 60000);
        fails++;
        end_of_test();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // one apb transfer; held until pready, then released for one cycle
    task automatic apb(input bit wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask

    // cycles between two rising edges of one pwm output
    task automatic period(input bit b);
        int t0;
        logic prev, cur;
        t0 = -1;
        gap = -1;
        prev = 1;
        for (int c = 0; c < 6000 && gap < 0; c++) begin
            @(posedge clk);
            cur = b ? pwm_b : pwm_a;
            if (cur === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = c;
                else gap = c - t0;
            end
            prev = cur;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, srd, st_a, st_b} = 0;
        paddr = 0;
        pwdata = 0;
        phase = PVAC_PH_HOLD;
        speed = 0;
        ustep = 8'hff;
        level = 5'h10;
        rst_n = 0;
        fails = 0;
        check_count = 0;
        void'($urandom(32'heae53a56));
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        // reset values of every writable register except the interrupt mask and status
        for (int i = 0; i < 11; i++) begin
            mdl[i] = (i < 4 || i == 6 || i == 7) ? `PVAC_RST_KVAL :
                i == 4 ? `PVAC_RST_INTSPD : i == 5 ? `PVAC_RST_STSLP :
                i == 8 ? 0 : i == 9 ? `PVAC_RST_CONFIG : 0;
            apb(0, ra[i], 0);
            chk(rd, mdl[i], "reset value");
        end
        $display("test reset values done");
        // pwm period from the reset divide and multiply fields
        period(0);
        chk(gap, 512 * `PVAC_OSC_PRESCALE * 2 / 4, "pwm a period");
        period(1);
        chk(gap, 512 * `PVAC_OSC_PRESCALE * 2 / 4, "pwm b period");
        $display("test pwm rate done");
        // unmapped place is refused
        apb(0, 12'h0ff0, 0);
        chk(err, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
        // random write and readback, with motion inputs varying
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 11; i++) begin
                mdl[i] = $urandom & msk[i];
                phase <= 4'h1 << (r + i) % 4;
                speed <= 20'($urandom);
                apb(1, ra[i], mdl[i]);
                apb(0, ra[i], 0);
                chk(rd, mdl[i], "readback");
            end
        end
        $display("test register access done");
        // low speed fix forces profile minimum to zero
        speed <= 20'h0_0000;
        apb(1, `PVAC_OFF_MINSPD, 32'h0000_1123);
        repeat (3) @(posedge clk);
        chk(lsa, 1, "low speed on");
        chk(pmin, 0, "min forced zero");
        apb(1, `PVAC_OFF_MINSPD, 32'h0000_0123);
        repeat (3) @(posedge clk);
        chk(lsa, 0, "low speed off");
        chk(pmin, 13'h0123, "min passes");
        $display("test low speed done");
        // holding: no bemf, unity supply, thermal factor 1+k/16, half step
        phase <= PVAC_PH_HOLD;
        ustep <= 8'h80;
        apb(1, `PVAC_OFF_CONFIG, `PVAC_RST_CONFIG);
        apb(1, `PVAC_OFF_KHOLD, 32'h0000_0040);
        for (int k = 0; k < 16; k += 5) begin
            apb(1, `PVAC_OFF_KTHERM, k);
            repeat (2) @(posedge clk);
            apb(0, `PVAC_OFF_AMP, 0);
            chk(rd, ((64 + 64 * k / 16) * 128) / 256, "amplitude");
        end
        $display("test amplitude done");
        // stall on bridge a holds its flag until a status read
        apb(1, `PVAC_OFF_IRQSTAT, 32'h0000_0007);
        st_a <= 1;
        @(posedge clk);
        st_a <= 0;
        repeat (20) @(posedge clk);
        chk(fl_a_n, 0, "flag a low");
        chk(fl_b_n, 1, "flag b idle");
        apb(0, `PVAC_OFF_IRQSTAT, 0);
        chk(rd & 3, 1, "stall status");
        apb(1, `PVAC_OFF_IRQMASK, 0);
        irq0 = irq;
        apb(1, `PVAC_OFF_IRQMASK, 32'h0000_0007);
        @(posedge clk);
        chk(irq0 ^ irq, 1, "mask changes irq");
        srd <= 1;
        @(posedge clk);
        srd <= 0;
        repeat (3) @(posedge clk);
        chk(fl_a_n, 1, "flag a released");
        apb(1, `PVAC_OFF_IRQSTAT, 32'h0000_0003);
        apb(0, `PVAC_OFF_IRQSTAT, 0);
        chk(rd & 3, 0, "status cleared");
        $display("test stall done");
        end_of_test();
    end
endmodule
